// *** ral_seq_host.sv ***
// host-side authentication sequencer for upstream or repeater host
`timescale 1ns/10ps
`include "ral_seq_regs.svh"
module ral_seq_host #(
  parameter int WAIT_CYCLES = `RAL_KL_WAIT_US * `RAL_CLK_MHZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // software register port
  input  wire logic [7:0] swAddr,
  input  wire logic [31:0] swWdata,
  input  wire logic       swWr,
  input  wire logic       swRd,
  output logic     [31:0] swRdata,
  // device control-channel access
  output logic            devReq,
  output logic            devWrite,
  output logic      [7:0] devAddr,
  output logic      [7:0] devWdata,
  input  wire logic       devAck,
  input  wire logic       devAckOk,
  input  wire logic [7:0] devRdata,
  // device pins
  input  wire logic       autoStartPin,
  input  wire logic       vsync,
  input  wire logic       authBegunPin,
  input  wire logic       encFollowPin,
  // status
  output logic            protectedOk
);
  import ral_seq_pkg::*;

  // a count beyond the counter width would wrap and cut every wait short
  if (WAIT_CYCLES < 1 || WAIT_CYCLES > 24'hffffff) begin : g_bad_wait
    $error("WAIT_CYCLES out of range");
  end

  ral_state_t  state_reg;
  logic  [3:0] step_reg;
  logic [23:0] cnt_reg;
  logic        adv_reg;
  logic        vsPrev_reg;
  logic        done_reg;
  logic  [3:0] ctrl_reg;
  logic  [7:0] seed_reg;
  logic  [7:0] key_reg;
  logic  [7:0] topo_reg;
  ral_op_t     opCur;
  logic  [7:0] dAddr;
  logic  [7:0] dData;
  logic  [7:0] dBit;
  logic        skip;
  logic        vsFall;
  logic        bitSet;
  logic        goPulse;
  logic        rpt;

  assign rpt     = ctrl_reg[`RAL_CTRL_RPT];
  assign vsFall  = vsPrev_reg & ~vsync;
  assign bitSet  = |(devRdata & dBit);
  assign goPulse = swWr && swAddr == `RAL_SW_CTRL && swWdata[`RAL_CTRL_GO];
  assign devReq  = state_reg == ST_ACK;
  assign protectedOk = done_reg;

  // ************************************************************
  // step table: upstream steps or repeater steps
  // ************************************************************
  always_comb begin
    opCur = OP_END;
    dAddr = 8'h00;
    dData = 8'h00;
    dBit  = 8'h00;
    skip  = 1'b0;
    if (!rpt) begin
      case (step_reg)
        4'h0: begin
          opCur = OP_WR; dAddr = `RAL_DEV_MASK; dData = `RAL_V_MASK;
          skip = ~ctrl_reg[`RAL_CTRL_MASK];
        end
        4'h1: begin
          opCur = OP_WR; dAddr = `RAL_DEV_LINK; dData = `RAL_V_ONE;
          skip = ~autoStartPin;
        end
        4'h2: begin
          opCur = OP_POLL; dAddr = `RAL_DEV_LOCK; dBit = `RAL_B_LOCK;
        end
        4'h3: begin
          opCur = OP_WR; dAddr = `RAL_DEV_SEED; dData = seed_reg;
          skip = ~ctrl_reg[`RAL_CTRL_SEED];
        end
        4'h4: begin
          opCur = OP_WR; dAddr = `RAL_DEV_AUTH; dData = `RAL_V_ONE;
        end
        4'h5: begin
          opCur = OP_WR; dAddr = `RAL_DEV_VFY; dData = `RAL_V_ONE;
        end
        4'h6: opCur = OP_VSF;
        4'h7: begin
          // device holds it pending till the next falling edge
          opCur = OP_WR; dAddr = `RAL_DEV_ENC; dData = `RAL_V_ONE;
        end
        4'h8: begin
          opCur = OP_RDBR; dAddr = `RAL_DEV_RELAY; dBit = `RAL_B_RELAY;
        end
        4'h9: opCur = OP_DLY;
        4'ha: begin
          opCur = OP_POLL; dAddr = `RAL_DEV_KLR; dBit = `RAL_B_KLR;
        end
        default: opCur = OP_END;
      endcase
    end else begin
      case (step_reg)
        4'h0: begin
          opCur = OP_WR; dAddr = `RAL_DEV_RELAY; dData = `RAL_V_ONE;
        end
        4'h1: begin
          opCur = OP_WR; dAddr = `RAL_DEV_LINK; dData = `RAL_V_ONE;
          skip = ~autoStartPin;
        end
        4'h2: begin
          opCur = OP_POLL; dAddr = `RAL_DEV_LOCK; dBit = `RAL_B_LOCK;
        end
        4'h3: begin
          opCur = OP_WR; dAddr = `RAL_DEV_GPIOF; dData = `RAL_V_GPIOF;
        end
        4'h4: begin
          opCur = OP_WR; dAddr = `RAL_DEV_SEED; dData = seed_reg;
          skip = ~ctrl_reg[`RAL_CTRL_SEED];
        end
        4'h5: opCur = OP_AUTH;
        4'h6: begin
          opCur = OP_WR; dAddr = `RAL_DEV_AUTH; dData = `RAL_V_ONE;
        end
        4'h7: begin
          opCur = OP_WR; dAddr = `RAL_DEV_VFY; dData = `RAL_V_ONE;
        end
        4'h8: opCur = OP_ENCF;
        4'h9: begin
          opCur = OP_WR; dAddr = `RAL_DEV_ENC; dData = `RAL_V_ONE;
        end
        4'ha: begin
          opCur = OP_WR; dAddr = `RAL_DEV_CC; dData = `RAL_V_CC_OFF;
        end
        4'hb: begin
          opCur = OP_WR; dAddr = `RAL_DEV_KEYL; dData = key_reg;
        end
        4'hc: begin
          opCur = OP_WR; dAddr = `RAL_DEV_TOPO; dData = topo_reg;
        end
        4'hd: begin
          opCur = OP_WR; dAddr = `RAL_DEV_KLR; dData = `RAL_V_ONE;
        end
        4'he: begin
          opCur = OP_WR; dAddr = `RAL_DEV_CC; dData = `RAL_V_CC_ON;
        end
        default: opCur = OP_END;
      endcase
    end
  end

  // ************************************************************
  // sequencer state
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      step_reg  <= 4'h0;
      adv_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (goPulse) begin
            state_reg <= ST_EXEC;
            step_reg  <= 4'h0;
          end
        end
        ST_EXEC: begin
          if (skip) begin
            step_reg <= step_reg + 4'h1;
          end else begin
            case (opCur)
              OP_WR, OP_POLL, OP_RDBR: state_reg <= ST_ACK;
              OP_AUTH: if (authBegunPin) step_reg <= step_reg + 4'h1;
              OP_ENCF: if (encFollowPin) step_reg <= step_reg + 4'h1;
              OP_VSF:  if (vsFall) step_reg <= step_reg + 4'h1;
              OP_DLY: begin
                state_reg <= ST_DLY;
                adv_reg   <= 1'b1;
              end
              default: state_reg <= ST_DONE;
            endcase
          end
        end
        ST_ACK: begin
          // a refused frame drops the request one cycle and tries again
          if (devAck) begin
            state_reg <= ST_EXEC;
            if (devAckOk) begin
              if (opCur == OP_WR || bitSet) begin
                step_reg <= step_reg + 4'h1;
              end else if (opCur == OP_RDBR) begin
                state_reg <= ST_DONE;
              end else begin
                state_reg <= ST_DLY;
                adv_reg   <= 1'b0;
              end
            end
          end
        end
        ST_DLY: begin
          if (cnt_reg == 24'h000000) begin
            state_reg <= ST_EXEC;
            if (adv_reg) step_reg <= step_reg + 4'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // wait counter, vsync history and completion flag
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= 24'h000000;
    end else if (state_reg != ST_DLY) begin
      cnt_reg <= 24'(WAIT_CYCLES - 1);
    end else if (cnt_reg != 24'h000000) begin
      cnt_reg <= cnt_reg - 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) vsPrev_reg <= 1'b0;
    else vsPrev_reg <= vsync;
  end

  // a run frees protected content at its last step, or when the relay-node flag reads clear
  always_ff @(posedge clk) begin
    if (!reset_n) done_reg <= 1'b0;
    else if (goPulse) done_reg <= 1'b0;
    else if ((state_reg == ST_EXEC && !skip && opCur == OP_END) ||
             (state_reg == ST_ACK && devAck && devAckOk &&
              opCur == OP_RDBR && !bitSet))
      done_reg <= 1'b1;
  end

  // ************************************************************
  // device access latches
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      devWrite <= 1'b0;
      devAddr  <= 8'h00;
      devWdata <= 8'h00;
    end else if (state_reg == ST_EXEC) begin
      devWrite <= opCur == OP_WR;
      devAddr  <= dAddr;
      devWdata <= dData;
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= 4'h0;
      seed_reg <= 8'h00;
      key_reg  <= 8'h00;
      topo_reg <= 8'h00;
    end else if (swWr) begin
      case (swAddr)
        `RAL_SW_CTRL: ctrl_reg <= {swWdata[3:1], 1'b0};
        `RAL_SW_SEED: seed_reg <= swWdata[7:0];
        `RAL_SW_KEY:  key_reg  <= swWdata[7:0];
        `RAL_SW_TOPO: topo_reg <= swWdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      swRdata <= 32'h00000000;
    end else if (swRd) begin
      case (swAddr)
        `RAL_SW_CTRL:   swRdata <= {28'h0000000, ctrl_reg};
        `RAL_SW_STATUS: swRdata <= {20'h00000, step_reg, 1'b0,
                                    state_reg, 2'b00, done_reg,
                                    state_reg != ST_IDLE &&
                                    state_reg != ST_DONE};
        `RAL_SW_SEED:   swRdata <= {24'h000000, seed_reg};
        `RAL_SW_KEY:    swRdata <= {24'h000000, key_reg};
        `RAL_SW_TOPO:   swRdata <= {24'h000000, topo_reg};
        default:        swRdata <= 32'h00000000;
      endcase
    end else begin
      swRdata <= 32'h00000000;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_retry_nak: assert property (@(posedge clk) disable iff (!reset_n)
    devReq && devAck && !devAckOk |=> state_reg == ST_EXEC
      && $stable(step_reg) ##1 devReq)
    else $error("refused frame not retried");
  a_req_stable: assert property (@(posedge clk) disable iff (!reset_n)
    devReq && !devAck |=> devReq && $stable(devAddr) && $stable(devWdata))
    else $error("request changed before answer");
  a_vsync_wait: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_EXEC && opCur == OP_VSF && !vsFall |=> $stable(step_reg))
    else $error("encryption step left without vsync fall");
  a_auth_wait: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_EXEC && opCur == OP_AUTH && !authBegunPin
      |=> $stable(step_reg) && !devReq)
    else $error("first part began before auth-begun pin");
  a_encf_wait: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_EXEC && opCur == OP_ENCF && encFollowPin
      |=> step_reg == $past(step_reg) + 4'h1)
    else $error("follow pin seen but step not taken");
  a_prot_done: assert property (@(posedge clk) disable iff (!reset_n)
    protectedOk |-> state_reg == ST_DONE || state_reg == ST_IDLE)
    else $error("protected content freed mid sequence");
  a_poll_back: assert property (@(posedge clk) disable iff (!reset_n)
    devReq && devAck && devAckOk && opCur == OP_POLL && !bitSet
      |=> state_reg == ST_DLY ##1 cnt_reg == 24'(WAIT_CYCLES - 2)
        || WAIT_CYCLES == 1)
    else $error("poll did not back off");
  a_auto_skip: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_EXEC && dAddr == `RAL_DEV_LINK && !autoStartPin
      |=> !devReq && step_reg == $past(step_reg) + 4'h1)
    else $error("link enable written while auto-start low");
endmodule

// *** ral_seq_regs.svh ***
// constants for the repeater authentication link sequencer
// Behaviour
// - Upstream host masks the A/V input before the link starts.
// - Link starts on serial link enable write, or by itself when auto-start low.
// - Repeater host enables downstream links unless their auto-start pin is low.
// - Each host confirms receiver lock before going on.
// - Host may load a random seed into its serializer first.
// - Repeater host sets both GPIO function selects to one.
// - Repeater host waits for auth-begun pin high before its first part.
// - Upstream host waits for a vsync falling edge, then enables encryption.
// - Relay-node flag set: second part runs, protected content withheld.
// - Repeater host enables encryption once encryption-follow pin is high.
// - Repeater host blocks control channel, retrying until acknowledged.
// - Input receiver stops relaying once both enables are zero.
// - Upstream host waits, then polls key-list-ready until acknowledged and one.
// - Repeater host writes key list, then topology info.
// - Topology-info write makes the receiver compute the list hash.
// - Repeater host sets key-list-ready first, then re-enables control channel.
// - Input receiver relays again once both enables are one.
// - Transmitter key write sets auth-begun flag and pin.
// - First GPIO pin follows the receiver encryption enable.
// - Repeater host sets relay-node flag before upstream first part.
`ifndef RAL_SEQ_REGS_SVH
`define RAL_SEQ_REGS_SVH
// ************************************************************
// software register offsets
// ************************************************************
`define RAL_SW_CTRL   8'h00
`define RAL_SW_STATUS 8'h04
`define RAL_SW_SEED   8'h08
`define RAL_SW_KEY    8'h0c
`define RAL_SW_TOPO   8'h10
`define RAL_CTRL_GO   0
`define RAL_CTRL_RPT  1
`define RAL_CTRL_MASK 2
`define RAL_CTRL_SEED 3
// ************************************************************
// device register addresses and values on the control channel
// ************************************************************
`define RAL_DEV_MASK  8'h01
`define RAL_DEV_LINK  8'h02
`define RAL_DEV_LOCK  8'h03
`define RAL_DEV_SEED  8'h10
`define RAL_DEV_RELAY 8'h11
`define RAL_DEV_GPIOF 8'h12
`define RAL_DEV_AUTH  8'h13
`define RAL_DEV_VFY   8'h14
`define RAL_DEV_ENC   8'h15
`define RAL_DEV_CC    8'h04
`define RAL_DEV_KEYL  8'h20
`define RAL_DEV_TOPO  8'h21
`define RAL_DEV_KLR   8'h22
`define RAL_V_ONE     8'h01
`define RAL_V_MASK    8'h03
`define RAL_V_GPIOF   8'h03
`define RAL_V_CC_ON   8'h03
`define RAL_V_CC_OFF  8'h00
`define RAL_B_LOCK    8'h01
`define RAL_B_RELAY   8'h01
`define RAL_B_KLR     8'h01
// ************************************************************
// timing
// ************************************************************
`define RAL_CLK_MHZ   200
`define RAL_KL_WAIT_US 100
`endif

// *** ral_seq_pkg.sv ***
// types shared by the repeater authentication link sequencer
package ral_seq_pkg;
  typedef enum logic [2:0] {
    OP_WR   = 3'b000,
    OP_POLL = 3'b001,
    OP_RDBR = 3'b010,
    OP_AUTH = 3'b011,
    OP_ENCF = 3'b100,
    OP_VSF  = 3'b101,
    OP_DLY  = 3'b110,
    OP_END  = 3'b111
  } ral_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_ACK  = 3'b010,
    ST_DLY  = 3'b011,
    ST_DONE = 3'b100
  } ral_state_t;
endpackage

// *** ral_dev_model.sv ***
// behavioural model of the serializer and receiver register space
`timescale 1ns/10ps
`include "ral_seq_regs.svh"
module ral_dev_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control-channel access from the host
  input  wire logic       devReq,
  input  wire logic       devWrite,
  input  wire logic [7:0] devAddr,
  input  wire logic [7:0] devWdata,
  output logic            devAck,
  output logic            devAckOk,
  output logic      [7:0] devRdata,
  // scenario knobs and device status
  input  wire logic [2:0] lat,
  input  wire logic [7:0] refuseAddr,
  input  wire logic       lockBit,
  input  wire logic       relayBit,
  input  wire logic       klrBit,
  input  wire logic       vsync,
  output logic            encActive,
  output logic            ccOpen
);
  // ************************************************************
  // register space and answers
  // ************************************************************
  logic [7:0] mem [256];
  logic [2:0] waitCnt;
  logic       refusedReg;
  logic       vsyncQ;
  logic [7:0] rdVal;
  logic       okNow;
  // lock bit reads back as the bench sets it; relay and key-list-ready bits read the bench bit ORed with the stored byte
  always_comb begin
    rdVal = mem[devAddr];
    if (devAddr == `RAL_DEV_LOCK) rdVal = {7'h0, lockBit};
    if (devAddr == `RAL_DEV_RELAY) rdVal = rdVal | {7'h0, relayBit};
    if (devAddr == `RAL_DEV_KLR) rdVal = rdVal | {7'h0, klrBit};
    okNow = (devAddr != refuseAddr) || refusedReg;
  end
  // answer after lat cycles; first access to refuseAddr is refused with devAckOk low
  always_ff @(posedge clk) begin
    devAck <= 1'b0;
    devRdata <= ~devRdata;  // read data never lingers on the lines
    if (!reset_n) begin
      mem <= '{default: 8'h00};
      mem[`RAL_DEV_CC] <= `RAL_V_CC_ON;
      waitCnt <= 3'h0;
      refusedReg <= 1'b0;
      devAckOk <= 1'b0;
      devRdata <= 8'h5a;
    end else if (devReq && !devAck) begin
      if (waitCnt == lat) begin
        waitCnt <= 3'h0;
        devAck <= 1'b1;
        devAckOk <= okNow;
        if (devAddr == refuseAddr) refusedReg <= 1'b1;
        if (okNow && devWrite) mem[devAddr] <= devWdata;
        if (okNow && !devWrite) devRdata <= rdVal;
      end else begin
        waitCnt <= waitCnt + 3'h1;
      end
    end
  end
  // a mid-frame enable waits for the next vsync falling edge
  always_ff @(posedge clk) begin
    vsyncQ <= vsync;
    if (!reset_n) encActive <= 1'b0;
    else if (vsyncQ && !vsync) encActive <= mem[`RAL_DEV_ENC][0];
  end
  // relaying needs both channel enables set
  assign ccOpen = (mem[`RAL_DEV_CC][1:0] == 2'b11);
endmodule

// *** repeater_auth_link_sequencer_bench.sv ***
// self-checking bench for the host authentication sequencer
`timescale 1ns/10ps
`include "ral_seq_regs.svh"
module repeater_auth_link_sequencer_bench;
  logic        clk, reset_n, swWr, swRd, devReq, devWrite, devAck;
  logic        devAckOk, autoStartPin, vsync, authBegunPin;
  logic        encFollowPin, protectedOk, lockBit, relayBit, klrBit;
  logic        encActive, ccOpen;
  logic [7:0]  swAddr, devAddr, devWdata, devRdata, refuseAddr;
  logic [31:0] swWdata, swRdata, rd;
  logic [2:0]  lat;
  logic [15:0] logQ[$];
  logic [15:0] expQ[$];
  int          err_total, n_checks;
  // short backoff keeps every poll loop brief
  ral_seq_host #(.WAIT_CYCLES(4)) u_dut (.clk(clk), .reset_n(reset_n),
    .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd),
    .swRdata(swRdata), .devReq(devReq), .devWrite(devWrite),
    .devAddr(devAddr), .devWdata(devWdata), .devAck(devAck),
    .devAckOk(devAckOk), .devRdata(devRdata),
    .autoStartPin(autoStartPin), .vsync(vsync),
    .authBegunPin(authBegunPin), .encFollowPin(encFollowPin),
    .protectedOk(protectedOk));
  ral_dev_model u_dev (.clk(clk), .reset_n(reset_n), .devReq(devReq),
    .devWrite(devWrite), .devAddr(devAddr), .devWdata(devWdata),
    .devAck(devAck), .devAckOk(devAckOk), .devRdata(devRdata),
    .lat(lat), .refuseAddr(refuseAddr), .lockBit(lockBit),
    .relayBit(relayBit), .klrBit(klrBit), .vsync(vsync),
    .encActive(encActive), .ccOpen(ccOpen));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // log every acknowledged device write
  always @(posedge clk) begin
    if (reset_n && devAck && devAckOk && devWrite) begin
      logQ.push_back({devAddr, devWdata});
    end
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic sw_wr(logic [7:0] a, logic [31:0] d);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic sw_rd(logic [7:0] a, output logic [31:0] d);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    #1;
    d = swRdata;
    @(posedge clk);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(protectedOk, 0);
  endtask
  function automatic int find(logic [7:0] a);
    foreach (expQ[i]) if (expQ[i][15:8] == a) return i;
    return 0;
  endfunction
  // expected device writes, in order, for one configuration
  function automatic void build(bit rpt, bit mask, bit sd, bit au,
                                logic [7:0] s, logic [7:0] k, logic [7:0] t);
    expQ = {};
    if (rpt) expQ.push_back({`RAL_DEV_RELAY, `RAL_V_ONE});
    if (!rpt && mask) expQ.push_back({`RAL_DEV_MASK, `RAL_V_MASK});
    if (au) expQ.push_back({`RAL_DEV_LINK, `RAL_V_ONE});
    if (rpt) expQ.push_back({`RAL_DEV_GPIOF, `RAL_V_GPIOF});
    if (sd) expQ.push_back({`RAL_DEV_SEED, s});
    expQ.push_back({`RAL_DEV_AUTH, `RAL_V_ONE});
    expQ.push_back({`RAL_DEV_VFY, `RAL_V_ONE});
    expQ.push_back({`RAL_DEV_ENC, `RAL_V_ONE});
    if (rpt) begin
      expQ.push_back({`RAL_DEV_CC, `RAL_V_CC_OFF});
      expQ.push_back({`RAL_DEV_KEYL, k});
      expQ.push_back({`RAL_DEV_TOPO, t});
      expQ.push_back({`RAL_DEV_KLR, `RAL_V_ONE});
      expQ.push_back({`RAL_DEV_CC, `RAL_V_CC_ON});
    end
  endfunction
  // hold a start condition back, prove nothing moves, then let it go
  task automatic gate(int k, int which);
    int t;
    t = 0;
    while (logQ.size() < k && t < 3000) begin
      @(posedge clk);
      t++;
    end
    repeat (24) @(posedge clk);
    check(logQ.size(), k);
    case (which)
      0: lockBit <= 1'b1;
      1: authBegunPin <= 1'b1;
      2: encFollowPin <= 1'b1;
      default: vsync <= 1'b0;
    endcase
    @(posedge clk);
    vsync <= 1'b1;
  endtask
  // ************************************************************
  // one full sequence
  // ************************************************************
  task automatic run(bit rpt, bit mask, bit sd, bit au, bit rel);
    logic [7:0] s, k, tp;
    int t;
    s = 8'($urandom);
    k = 8'($urandom);
    tp = 8'($urandom);
    lat <= 3'($urandom);
    autoStartPin <= au;
    relayBit <= rel;
    {lockBit, klrBit, authBegunPin, encFollowPin} <= 4'h0;
    refuseAddr <= rpt ? `RAL_DEV_CC : `RAL_DEV_AUTH;
    do_reset();
    sw_wr(`RAL_SW_SEED, {24'h0, s});
    sw_wr(`RAL_SW_KEY, {24'h0, k});
    sw_wr(`RAL_SW_TOPO, {24'h0, tp});
    build(rpt, mask, sd, au, s, k, tp);
    logQ = {};
    sw_wr(`RAL_SW_CTRL, {28'h0, sd, mask, rpt, 1'b1});
    gate(rpt ? 1 + au : mask + au, 0);
    if (rpt) begin
      gate(find(`RAL_DEV_AUTH), 1);
      gate(find(`RAL_DEV_ENC), 2);
    end else begin
      gate(find(`RAL_DEV_ENC), 3);
      if (rel) begin
        repeat (60) @(posedge clk);
        check(protectedOk, 0);
        klrBit <= 1'b1;
      end
    end
    t = 0;
    while (protectedOk !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    check(protectedOk, 1);
    check(ccOpen, 1);
    vsync <= 1'b0;
    @(posedge clk);
    vsync <= 1'b1;
    repeat (2) @(posedge clk);
    check(encActive, 1);
    check(logQ.size(), expQ.size());
    foreach (expQ[i]) check(logQ[i], expQ[i]);
    sw_rd(`RAL_SW_STATUS, rd);
    check(rd[1:0], 2'b10);
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {clk, reset_n, swWr, swRd, vsync, autoStartPin} = 6'h03;
    {lockBit, relayBit, klrBit, authBegunPin, encFollowPin} = 5'h0;
    {swAddr, swWdata, lat, refuseAddr} = '0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(3));
    run(0, 1, 1, 1, 0);
    run(0, 0, 0, 0, 1);
    run(1, 1, 1, 1, 0);
    run(1, 0, 0, 0, 0);
    repeat (4) begin
      run(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
          1'($urandom));
    end
    sw_rd(8'h3c, rd);
    check(rd, 0);
    sw_rd(`RAL_SW_CTRL, rd);
    check(rd[0], 0);
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
